// ===== design/olct_pkg.sv
// Package for the output line control timers: register map, fields, types
package olct_pkg;
    localparam int NUM_LINES = 4;
    localparam int RAW_W = 12;
    localparam int BASE_W = 16;
    // Register byte offsets
    localparam logic [7:0] OFS_LINE_SEL = 8'h00;
    localparam logic [7:0] OFS_LINE_SRC = 8'h04;
    localparam logic [7:0] OFS_LINE_INV = 8'h08;
    localparam logic [7:0] OFS_USER_SEL = 8'h0C;
    localparam logic [7:0] OFS_USER_VAL = 8'h10;
    localparam logic [7:0] OFS_USER_ALL = 8'h14;
    localparam logic [7:0] OFS_TMR_SEL = 8'h18;
    localparam logic [7:0] OFS_TMR_DELAY = 8'h1C;
    localparam logic [7:0] OFS_TMR_DUR = 8'h20;
    localparam logic [7:0] OFS_DELAY_BASE = 8'h24;
    localparam logic [7:0] OFS_DUR_BASE = 8'h28;
    localparam logic [7:0] OFS_TMR_TRIG = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    // Reset values and limits
    localparam logic [RAW_W-1:0] DELAY_RAW_RST = 12'h000;
    localparam logic [RAW_W-1:0] DUR_RAW_MIN = 12'h001;
    localparam logic [RAW_W-1:0] DUR_RAW_RST = 12'h001;
    localparam logic [BASE_W-1:0] BASE_MIN = 16'h0001;
    localparam logic [BASE_W-1:0] BASE_RST = 16'h0001;
    localparam logic [1:0] TRIG_EXP_START = 2'h0;
    // Timing: one microsecond of a 125 MHz clock
    localparam int CLK_MHZ = 125;
    localparam int TICK_US = 1;
    localparam int TICK_CYC = TICK_US * CLK_MHZ;
    localparam logic [6:0] TICK_LAST = 7'(TICK_CYC - 1);

    typedef enum logic [1:0] {
        OLCT_SRC_EXPOSURE,
        OLCT_SRC_TRIG_READY,
        OLCT_SRC_TIMER,
        OLCT_SRC_USER
    } olct_src_t;

    typedef enum logic [1:0] {OLCT_T_IDLE, OLCT_T_DELAY, OLCT_T_DUR} olct_tstate_t;

    // Per-timer settings
    typedef struct packed {
        logic [RAW_W-1:0] delayRaw;
        logic [RAW_W-1:0] durRaw;
    } olct_tcfg_t;

    // Per-line settings
    typedef struct packed {
        olct_src_t src;
        logic invert;
    } olct_lcfg_t;
endpackage

// ===== design/olct_timer.sv
// One delay/duration pulse timer that counts its own microseconds and base units
`timescale 1ns/100ps
module olct_timer (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic startPulse,
    input wire logic [olct_pkg::BASE_W-1:0] delayBase,
    input wire logic [olct_pkg::BASE_W-1:0] durBase,
    input wire olct_pkg::olct_tcfg_t cfg,
    output logic timerOut,
    output logic busy
);
    olct_pkg::olct_tstate_t state_r, state_nxt;
    logic [olct_pkg::RAW_W-1:0] count_r, count_nxt;
    logic [6:0] cycCnt_r, cycCnt_nxt;
    logic [olct_pkg::BASE_W-1:0] unitCnt_r, unitCnt_nxt;
    logic [olct_pkg::BASE_W-1:0] baseNow;
    logic usEnd;
    logic unitEnd;

    // Next state; unit timing restarts per phase, so no first unit is cut short
    always_comb begin
        state_nxt = state_r;
        count_nxt = count_r;
        usEnd = (cycCnt_r == olct_pkg::TICK_LAST);
        baseNow = (state_r == olct_pkg::OLCT_T_DUR) ? durBase : delayBase;
        unitEnd = usEnd && (unitCnt_r >= baseNow - 16'h0001);
        cycCnt_nxt = usEnd ? 7'h00 : cycCnt_r + 7'h01;
        unitCnt_nxt = unitCnt_r;
        if (usEnd) begin
            unitCnt_nxt = unitEnd ? 16'h0000 : unitCnt_r + 16'h0001;
        end
        unique case (state_r)
            olct_pkg::OLCT_T_IDLE: begin
                cycCnt_nxt = 7'h00;
                unitCnt_nxt = 16'h0000;
                if (startPulse) begin
                    if (cfg.delayRaw == '0) begin
                        state_nxt = olct_pkg::OLCT_T_DUR;
                        count_nxt = cfg.durRaw;
                    end else begin
                        state_nxt = olct_pkg::OLCT_T_DELAY;
                        count_nxt = cfg.delayRaw;
                    end
                end
            end
            olct_pkg::OLCT_T_DELAY: begin
                if (unitEnd) begin
                    if (count_r == 12'h001) begin
                        state_nxt = olct_pkg::OLCT_T_DUR;
                        count_nxt = cfg.durRaw;
                    end else begin
                        count_nxt = count_r - 12'h001;
                    end
                end
            end
            olct_pkg::OLCT_T_DUR: begin
                if (unitEnd) begin
                    if (count_r <= 12'h001) begin
                        state_nxt = olct_pkg::OLCT_T_IDLE;
                        count_nxt = '0;
                    end else begin
                        count_nxt = count_r - 12'h001;
                    end
                end
            end
            default: begin
                state_nxt = olct_pkg::OLCT_T_IDLE;
                count_nxt = '0;
            end
        endcase
    end

    // Registers
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_r <= olct_pkg::OLCT_T_IDLE;
            count_r <= '0;
            cycCnt_r <= 7'h00;
            unitCnt_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            count_r <= count_nxt;
            cycCnt_r <= cycCnt_nxt;
            unitCnt_r <= unitCnt_nxt;
        end
    end

    assign timerOut = (state_r == olct_pkg::OLCT_T_DUR);
    assign busy = (state_r != olct_pkg::OLCT_T_IDLE);

    a_delay_before_high: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == olct_pkg::OLCT_T_DELAY) |-> !timerOut)
        else $error("timer high during delay");
    a_busy_no_restart: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == olct_pkg::OLCT_T_DUR && startPulse && !unitEnd) |=> timerOut)
        else $error("start disturbed busy timer");
    a_zero_delay_high: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == olct_pkg::OLCT_T_IDLE && startPulse && cfg.delayRaw == '0) |=> timerOut)
        else $error("zero delay did not go high at once");
    a_delay_on_tick: assert property (@(posedge clk_sys) disable iff (reset)
        (state_r == olct_pkg::OLCT_T_DELAY && !unitEnd) |=> state_r == olct_pkg::OLCT_T_DELAY)
        else $error("delay advanced without tick");
    a_tick_period: assert property (@(posedge clk_sys) disable iff (reset)
        usEnd |=> !usEnd [*8])
        else $error("microsecond tick too frequent");
endmodule

// ===== design/olct_output_lines.sv
// Output line routing, inversion, user values and pulse timers behind APB
//
// Functional notes
// - Each line selects exposure active, trigger ready, its timer or user level.
// - Reset routes line 1 to exposure active and line 2 to trigger ready.
// - Selected user output value true drives high, false drives low.
// - 32-bit all-user word, low four bits set the four user outputs.
// - User level is applied before the line inverter.
// - Each line has its own inversion enable.
// - Timer waits delay, then high for duration, then low.
// - Exposure start is the only timer start event.
// - Timer N feeds only output line N.
// - Delay equals raw delay count times delay time base.
// - Raw delay 0 to 4095; zero means no delay.
// - Delay time base in microseconds, minimum and reset value one.
// - One delay time base shared by all four timers.
// - Duration equals raw duration times shared duration base, default one microsecond.
// - Raw duration 1 to 4095.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
module olct_output_lines (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exposureActive,
    input wire logic triggerReady,
    output logic [3:0] outLines
);
    localparam int N = olct_pkg::NUM_LINES;

    // Software settings
    olct_pkg::olct_lcfg_t [N-1:0] lineCfg_r, lineCfg_nxt;
    olct_pkg::olct_tcfg_t [N-1:0] tmrCfg_r, tmrCfg_nxt;
    logic [1:0] lineSel_r, lineSel_nxt;
    logic [1:0] userSel_r, userSel_nxt;
    logic [1:0] tmrSel_r, tmrSel_nxt;
    logic [N-1:0] userVal_r, userVal_nxt;
    logic [olct_pkg::BASE_W-1:0] delayBase_r, delayBase_nxt;
    logic [olct_pkg::BASE_W-1:0] durBase_r, durBase_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;
    // Start logic; each timer paces its own microseconds
    logic expSync1_r, expSync2_r, expPrev_r;
    logic trigSync1_r, trigSync2_r;
    logic expStart;
    logic [N-1:0] timerOut, timerBusy;
    logic [N-1:0] lineNxt;
    logic [N-1:0] lines_r;

    // Address match helper used by both read and write decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // Clamp a base to its one-microsecond minimum
    function automatic logic [olct_pkg::BASE_W-1:0] clampBase(input logic [31:0] v);
        if (v[olct_pkg::BASE_W-1:0] < olct_pkg::BASE_MIN) begin
            clampBase = olct_pkg::BASE_MIN;
        end else begin
            clampBase = v[olct_pkg::BASE_W-1:0];
        end
    endfunction

    logic apbAccess;
    assign apbAccess = psel && penable && !pready_r;

    // APB slave: one wait state, answer on the cycle after access starts
    always_comb begin
        lineCfg_nxt = lineCfg_r;
        tmrCfg_nxt = tmrCfg_r;
        lineSel_nxt = lineSel_r;
        userSel_nxt = userSel_r;
        tmrSel_nxt = tmrSel_r;
        userVal_nxt = userVal_r;
        delayBase_nxt = delayBase_r;
        durBase_nxt = durBase_r;
        prdata_nxt = prdata_r;
        pready_nxt = apbAccess;
        pslverr_nxt = 1'b0;
        if (apbAccess && pwrite) begin
            if (hit(paddr, olct_pkg::OFS_LINE_SEL)) begin
                lineSel_nxt = pwdata[1:0];
            end else if (hit(paddr, olct_pkg::OFS_LINE_SRC)) begin
                lineCfg_nxt[lineSel_r].src = olct_pkg::olct_src_t'(pwdata[1:0]);
            end else if (hit(paddr, olct_pkg::OFS_LINE_INV)) begin
                lineCfg_nxt[lineSel_r].invert = pwdata[0];
            end else if (hit(paddr, olct_pkg::OFS_USER_SEL)) begin
                userSel_nxt = pwdata[1:0];
            end else if (hit(paddr, olct_pkg::OFS_USER_VAL)) begin
                userVal_nxt[userSel_r] = pwdata[0];
            end else if (hit(paddr, olct_pkg::OFS_USER_ALL)) begin
                userVal_nxt = pwdata[N-1:0];
            end else if (hit(paddr, olct_pkg::OFS_TMR_SEL)) begin
                tmrSel_nxt = pwdata[1:0];
            end else if (hit(paddr, olct_pkg::OFS_TMR_DELAY)) begin
                tmrCfg_nxt[tmrSel_r].delayRaw = pwdata[olct_pkg::RAW_W-1:0];
            end else if (hit(paddr, olct_pkg::OFS_TMR_DUR)) begin
                if (pwdata[olct_pkg::RAW_W-1:0] < olct_pkg::DUR_RAW_MIN) begin
                    tmrCfg_nxt[tmrSel_r].durRaw = olct_pkg::DUR_RAW_MIN;
                end else begin
                    tmrCfg_nxt[tmrSel_r].durRaw = pwdata[olct_pkg::RAW_W-1:0];
                end
            end else if (hit(paddr, olct_pkg::OFS_DELAY_BASE)) begin
                delayBase_nxt = clampBase(pwdata);
            end else if (hit(paddr, olct_pkg::OFS_DUR_BASE)) begin
                durBase_nxt = clampBase(pwdata);
            end else if (!hit(paddr, olct_pkg::OFS_TMR_TRIG)) begin
                pslverr_nxt = 1'b1;
            end
        end else if (apbAccess) begin
            prdata_nxt = 32'h00000000;
            if (hit(paddr, olct_pkg::OFS_LINE_SEL)) begin
                prdata_nxt[1:0] = lineSel_r;
            end else if (hit(paddr, olct_pkg::OFS_LINE_SRC)) begin
                prdata_nxt[1:0] = lineCfg_r[lineSel_r].src;
            end else if (hit(paddr, olct_pkg::OFS_LINE_INV)) begin
                prdata_nxt[0] = lineCfg_r[lineSel_r].invert;
            end else if (hit(paddr, olct_pkg::OFS_USER_SEL)) begin
                prdata_nxt[1:0] = userSel_r;
            end else if (hit(paddr, olct_pkg::OFS_USER_VAL)) begin
                prdata_nxt[0] = userVal_r[userSel_r];
            end else if (hit(paddr, olct_pkg::OFS_USER_ALL)) begin
                prdata_nxt[N-1:0] = userVal_r;
            end else if (hit(paddr, olct_pkg::OFS_TMR_SEL)) begin
                prdata_nxt[1:0] = tmrSel_r;
            end else if (hit(paddr, olct_pkg::OFS_TMR_DELAY)) begin
                prdata_nxt[olct_pkg::RAW_W-1:0] = tmrCfg_r[tmrSel_r].delayRaw;
            end else if (hit(paddr, olct_pkg::OFS_TMR_DUR)) begin
                prdata_nxt[olct_pkg::RAW_W-1:0] = tmrCfg_r[tmrSel_r].durRaw;
            end else if (hit(paddr, olct_pkg::OFS_DELAY_BASE)) begin
                prdata_nxt[olct_pkg::BASE_W-1:0] = delayBase_r;
            end else if (hit(paddr, olct_pkg::OFS_DUR_BASE)) begin
                prdata_nxt[olct_pkg::BASE_W-1:0] = durBase_r;
            end else if (hit(paddr, olct_pkg::OFS_TMR_TRIG)) begin
                prdata_nxt[1:0] = olct_pkg::TRIG_EXP_START;
            end else if (hit(paddr, olct_pkg::OFS_STATUS)) begin
                prdata_nxt[N-1:0] = lines_r;
                prdata_nxt[2*N-1:N] = timerBusy;
            end else begin
                pslverr_nxt = 1'b1;
            end
        end
    end

    // Register file; reset gives the default line assignment
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lineCfg_r[0] <= '{src: olct_pkg::OLCT_SRC_EXPOSURE, invert: 1'b0};
            lineCfg_r[1] <= '{src: olct_pkg::OLCT_SRC_TRIG_READY, invert: 1'b0};
            lineCfg_r[2] <= '{src: olct_pkg::OLCT_SRC_USER, invert: 1'b0};
            lineCfg_r[3] <= '{src: olct_pkg::OLCT_SRC_USER, invert: 1'b0};
            for (int i = 0; i < N; i++) begin
                tmrCfg_r[i] <= '{delayRaw: olct_pkg::DELAY_RAW_RST,
                                 durRaw: olct_pkg::DUR_RAW_RST};
            end
            lineSel_r <= 2'h0;
            userSel_r <= 2'h0;
            tmrSel_r <= 2'h0;
            userVal_r <= '0;
            delayBase_r <= olct_pkg::BASE_RST;
            durBase_r <= olct_pkg::BASE_RST;
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            lineCfg_r <= lineCfg_nxt;
            tmrCfg_r <= tmrCfg_nxt;
            lineSel_r <= lineSel_nxt;
            userSel_r <= userSel_nxt;
            tmrSel_r <= tmrSel_nxt;
            userVal_r <= userVal_nxt;
            delayBase_r <= delayBase_nxt;
            durBase_r <= durBase_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // Pins from other logic are synchronised before the edge detector
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            expSync1_r <= 1'b0;
            expSync2_r <= 1'b0;
            expPrev_r <= 1'b0;
            trigSync1_r <= 1'b0;
            trigSync2_r <= 1'b0;
        end else begin
            expSync1_r <= exposureActive;
            expSync2_r <= expSync1_r;
            expPrev_r <= expSync2_r;
            trigSync1_r <= triggerReady;
            trigSync2_r <= trigSync1_r;
        end
    end

    assign expStart = expSync2_r && !expPrev_r;

    // One timer per line; timer N can reach only line N
    for (genvar g = 0; g < N; g++) begin : gTimer
        olct_timer uTimer (
            .clk_sys(clk_sys),
            .reset(reset),
            .startPulse(expStart),
            .delayBase(delayBase_r),
            .durBase(durBase_r),
            .cfg(tmrCfg_r[g]),
            .timerOut(timerOut[g]),
            .busy(timerBusy[g])
        );
    end

    // Line mux; inversion sits after the source, user level included
    always_comb begin
        for (int i = 0; i < N; i++) begin
            unique case (lineCfg_r[i].src)
                olct_pkg::OLCT_SRC_EXPOSURE: lineNxt[i] = expSync2_r;
                olct_pkg::OLCT_SRC_TRIG_READY: lineNxt[i] = trigSync2_r;
                olct_pkg::OLCT_SRC_TIMER: lineNxt[i] = timerOut[i];
                olct_pkg::OLCT_SRC_USER: lineNxt[i] = userVal_r[i];
            endcase
            lineNxt[i] = lineNxt[i] ^ lineCfg_r[i].invert;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            lines_r <= '0;
        end else begin
            lines_r <= lineNxt;
        end
    end

    assign outLines = lines_r;

    a_user_level_pin: assert property (@(posedge clk_sys) disable iff (reset)
        (lineCfg_r[2].src == olct_pkg::OLCT_SRC_USER && $stable(lineCfg_r[2]))
        |=> outLines[2] == ($past(userVal_r[2]) ^ $past(lineCfg_r[2].invert)))
        else $error("user line level wrong");
    a_timer_route: assert property (@(posedge clk_sys) disable iff (reset)
        (lineCfg_r[3].src == olct_pkg::OLCT_SRC_TIMER && !lineCfg_r[3].invert)
        |=> outLines[3] == $past(timerOut[3]))
        else $error("timer 4 not on line 4");
    a_base_minimum: assert property (@(posedge clk_sys) disable iff (reset)
        delayBase_r >= olct_pkg::BASE_MIN && durBase_r >= olct_pkg::BASE_MIN)
        else $error("time base below minimum");
    // Live sources reach their own pin one cycle later, inverter last
    a_exposure_route: assert property (@(posedge clk_sys) disable iff (reset)
        (lineCfg_r[0].src == olct_pkg::OLCT_SRC_EXPOSURE && $stable(lineCfg_r[0]))
        |=> outLines[0] == ($past(expSync2_r) ^ $past(lineCfg_r[0].invert)))
        else $error("exposure line level wrong");
    a_trig_route: assert property (@(posedge clk_sys) disable iff (reset)
        (lineCfg_r[1].src == olct_pkg::OLCT_SRC_TRIG_READY && $stable(lineCfg_r[1]))
        |=> outLines[1] == ($past(trigSync2_r) ^ $past(lineCfg_r[1].invert)))
        else $error("trigger ready line level wrong");
    a_first_timer_route: assert property (@(posedge clk_sys) disable iff (reset)
        (lineCfg_r[0].src == olct_pkg::OLCT_SRC_TIMER && !lineCfg_r[0].invert)
        |=> outLines[0] == $past(timerOut[0]))
        else $error("timer 1 not on line 1");
    a_unmapped_read: assert property (@(posedge clk_sys) disable iff (reset)
        (apbAccess && !pwrite && paddr > olct_pkg::OFS_STATUS) |=> pslverr)
        else $error("unmapped read not refused");
    a_status_readonly: assert property (@(posedge clk_sys) disable iff (reset)
        (apbAccess && pwrite && paddr == olct_pkg::OFS_STATUS) |=> pslverr)
        else $error("status write not refused");
    a_ready_single: assert property (@(posedge clk_sys) disable iff (reset)
        pready |=> !pready)
        else $error("apb ready held too long");
    a_all_user_write: assert property (@(posedge clk_sys) disable iff (reset)
        (apbAccess && pwrite && paddr == olct_pkg::OFS_USER_ALL)
        |=> userVal_r == $past(pwdata[3:0]))
        else $error("all user word not stored");
    a_apb_answer: assert property (@(posedge clk_sys) disable iff (reset)
        (psel && penable && !pready) |=> pready)
        else $error("apb answer late");
endmodule

// ===== testbench/olct_line_sink.sv
// Far-side equipment model: watches the four output lines and times their pulses
`timescale 1ns/100ps
module olct_line_sink (
    input wire logic clk_sys,
    input wire logic [3:0] lines,
    output logic [31:0] nowCyc,
    output logic [3:0][31:0] riseCyc,
    output logic [3:0][31:0] highLen,
    output logic [3:0][7:0] pulses
);
    logic [3:0] prev = 4'h0;
    logic [3:0][31:0] runLen = '0;
    initial begin
        nowCyc = 32'h0;
        riseCyc = '0;
        highLen = '0;
        pulses = '0;
    end
    // Purely receiving inputs: records the last rise time and last high width per line
    always @(posedge clk_sys) begin
        nowCyc <= nowCyc + 32'h1;
        prev <= lines;
        for (int i = 0; i < 4; i++) begin
            if (lines[i] && !prev[i]) begin
                riseCyc[i] <= nowCyc;
                pulses[i] <= pulses[i] + 8'h1;
                runLen[i] <= 32'h1;
            end else if (lines[i]) begin
                runLen[i] <= runLen[i] + 32'h1;
            end else if (prev[i]) begin
                highLen[i] <= runLen[i]; // Width known only once the line falls
            end
        end
    end
endmodule

// ===== testbench/tb.sv
// Self-checking bench for the output line block: APB master, line sink, scenarios
`timescale 1ns/100ps
module tb;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic exposureActive = 1'b0;
    logic triggerReady = 1'b1;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:0] outLines;
    logic [31:0] nowCyc;
    logic [3:0][31:0] riseCyc;
    logic [3:0][31:0] highLen;
    logic [3:0][7:0] pulses;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int comparisons = 0;

    olct_output_lines i_dut (.clk_sys(clk_sys), .reset(reset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .exposureActive(exposureActive), .triggerReady(triggerReady), .outLines(outLines));
    olct_line_sink i_sink (.clk_sys(clk_sys), .lines(outLines), .nowCyc(nowCyc),
        .riseCyc(riseCyc), .highLen(highLen), .pulses(pulses));

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    // Verdict and end of run
    task automatic close_out;
        if (num_errors == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Case-equality compare so an unknown never passes
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("[FAIL] %0t apb timeout", $time);
            close_out();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    // Lets the input synchroniser and output register catch up
    task automatic settle;
        repeat (6) @(posedge clk_sys);
    endtask

    // Reset routing and register defaults, refused accesses
    task automatic t_reset;
        settle();
        chk(outLines, 32'h2, "reset lines"); // default route
        exposureActive <= 1'b1;
        settle();
        chk(outLines, 32'h3, "exposure on line 1"); // default route
        exposureActive <= 1'b0;
        apb(1'b0, olct_pkg::OFS_DELAY_BASE, 32'h0);
        chk(rd, 32'h1, "delay base reset"); // base one
        apb(1'b0, olct_pkg::OFS_DUR_BASE, 32'h0);
        chk(rd, 32'h1, "duration base reset"); // base one
        apb(1'b0, olct_pkg::OFS_TMR_DELAY, 32'h0);
        chk(rd, 32'h0, "delay raw reset"); // zero delay
        apb(1'b0, olct_pkg::OFS_TMR_DUR, 32'h0);
        chk(rd, 32'h1, "duration raw reset"); // minimum one
        apb(1'b1, olct_pkg::OFS_TMR_DUR, 32'h0);
        apb(1'b0, olct_pkg::OFS_TMR_DUR, 32'h0);
        chk(rd, 32'h1, "duration raw clamp"); // minimum one
        apb(1'b1, olct_pkg::OFS_DELAY_BASE, 32'h0);
        apb(1'b0, olct_pkg::OFS_DELAY_BASE, 32'h0);
        chk(rd, 32'h1, "delay base clamp"); // minimum one
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 32'h1, "unmapped read error");
        apb(1'b1, olct_pkg::OFS_STATUS, 32'hFFFFFFFF);
        chk(err, 32'h1, "status write error");
    endtask

    // All-user word, single user value and inversion ahead of the pin
    task automatic t_user;
        apb(1'b1, olct_pkg::OFS_USER_ALL, 32'hFFFFFFF5);
        settle();
        chk(outLines[3:2], 32'h1, "all-user lines"); // low bits
        apb(1'b0, olct_pkg::OFS_USER_ALL, 32'h0);
        chk(rd, 32'h5, "all-user readback"); // low bits
        apb(1'b1, olct_pkg::OFS_LINE_SEL, 32'h0);
        apb(1'b1, olct_pkg::OFS_LINE_SRC, 32'h3);
        apb(1'b1, olct_pkg::OFS_USER_SEL, 32'h0);
        for (int v = 0; v < 2; v++) begin
            apb(1'b1, olct_pkg::OFS_USER_VAL, 32'(v));
            settle();
            chk(outLines[0], 32'(v), "user value line 1"); // user level
        end
        apb(1'b1, olct_pkg::OFS_LINE_INV, 32'h1);
        settle();
        chk(outLines[0], 32'h0, "inverted user line"); // before inverter
    endtask

    // Source selection and inversion of live signals
    task automatic t_route;
        apb(1'b1, olct_pkg::OFS_LINE_SRC, 32'h0);
        exposureActive <= 1'b1;
        settle();
        chk(outLines[0], 32'h0, "inverted exposure"); // invert on
        apb(1'b1, olct_pkg::OFS_LINE_INV, 32'h0);
        settle();
        chk(outLines[0], 32'h1, "plain exposure"); // invert off
        triggerReady <= 1'b0;
        apb(1'b1, olct_pkg::OFS_LINE_SEL, 32'h1);
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, olct_pkg::OFS_LINE_SRC, 32'(s));
            settle();
            chk(outLines[1], 32'(1 - s), "line 2 source"); // source select
        end
        exposureActive <= 1'b0;
    endtask

    // Four timers on their own lines, shared bases, retrigger while busy
    task automatic t_timer;
        logic [3:0][7:0] cnt;
        logic [31:0] t0;
        int d;
        int len;
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, olct_pkg::OFS_LINE_SEL, 32'(i));
            apb(1'b1, olct_pkg::OFS_LINE_SRC, 32'h2);
            apb(1'b1, olct_pkg::OFS_LINE_INV, 32'h0);
            apb(1'b1, olct_pkg::OFS_TMR_SEL, 32'(i));
            apb(1'b1, olct_pkg::OFS_TMR_DELAY, 32'(i));
            apb(1'b1, olct_pkg::OFS_TMR_DUR, 32'(i + 1));
        end
        apb(1'b1, olct_pkg::OFS_DELAY_BASE, 32'h2);
        apb(1'b1, olct_pkg::OFS_DUR_BASE, 32'h2);
        apb(1'b1, olct_pkg::OFS_TMR_TRIG, 32'h0);
        apb(1'b0, olct_pkg::OFS_TMR_TRIG, 32'h0);
        chk(rd, 32'h0, "trigger source"); // exposure start
        settle();
        cnt = pulses;
        t0 = nowCyc;
        exposureActive <= 1'b1;
        repeat (10) @(posedge clk_sys);
        exposureActive <= 1'b0;
        repeat (100) @(posedge clk_sys);
        exposureActive <= 1'b1; // Second start lands while every timer is busy
        repeat (10) @(posedge clk_sys);
        exposureActive <= 1'b0;
        apb(1'b0, olct_pkg::OFS_STATUS, 32'h0);
        chk(rd, 32'hF1, "status while busy"); // busy timers
        repeat (2400) @(posedge clk_sys);
        // Rise lags by five: two sync stages, timer state register, line register, sink
        for (int i = 0; i < 4; i++) begin
            d = i * 2 * olct_pkg::TICK_CYC;
            len = (i + 1) * 2 * olct_pkg::TICK_CYC;
            chk(pulses[i] - cnt[i], 32'h1, "one pulse per line"); // busy ignore
            chk(riseCyc[i] - t0, 32'(d + 5), "timer delay"); // delay product
            chk(highLen[i], 32'(len), "timer duration"); // duration product
        end
    endtask

    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset();
        t_user();
        t_route();
        t_timer();
        close_out();
    end
endmodule
